// *** inc/ddr2_host_pkg.sv ***
// Shared constants for the DDR2 command controller: request operations,
// strobe encodings, burst and gate figures, and refresh timing.
// Assumes a 200 MHz system clock and a link clock made by dividing it by two.
package ddr2_host_pkg;

	// Operations that the user side may request.
	typedef enum logic [3:0] {
		OP_ROW_OPEN,
		OP_READ,
		OP_READ_AUTOCLOSE,
		OP_WRITE,
		OP_WRITE_AUTOCLOSE,
		OP_ROW_CLOSE,
		OP_ROW_CLOSE_ALL,
		OP_REFRESH,
		OP_CONFIG_WRITE,
		OP_POWER_DOWN,
		OP_SELF_REFRESH,
		OP_WAKE
	} op_t;

	// Strobe codes, ordered {chip_select_n, row, column, write strobe}.
	localparam logic [3:0] CMD_DESELECT = 4'h8;
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_ROW_OPEN = 4'h3;
	localparam logic [3:0] CMD_READ = 4'h5;
	localparam logic [3:0] CMD_WRITE = 4'h4;
	localparam logic [3:0] CMD_ROW_CLOSE = 4'h2;
	localparam logic [3:0] CMD_REFRESH = 4'h1;
	localparam logic [3:0] CMD_CONFIG = 4'h0;

	// Address bit that selects auto-close or all-bank close.
	localparam int AUTOCLOSE_BIT = 10;

	// Burst and gate figures, in link clock cycles.
	localparam int BURST_LENGTH = 4;
	localparam int GATE_MIN_HOLD = 3;
	localparam int EXIT_READ_DELAY = 200;

	// Clocking: the link clock is the system clock divided by two.
	localparam int SYS_PERIOD_PS = 5000;
	localparam int LINK_DIV = 2;
	localparam int LINK_PERIOD_PS = SYS_PERIOD_PS * LINK_DIV;

	// Refresh interval of 15.6 us; a longest time, so it rounds down.
	localparam int REFRESH_INTERVAL_NS = 15600;
	localparam int REFRESH_INTERVAL_CYC =
		(REFRESH_INTERVAL_NS * 1000) / LINK_PERIOD_PS;

	// Power-down may last at most nine refresh intervals.
	localparam int POWER_DOWN_INTERVALS = 9;
	localparam int POWER_DOWN_MAX_DEF =
		POWER_DOWN_INTERVALS * REFRESH_INTERVAL_CYC;

	// Width of the general purpose cycle counters.
	localparam int CNT_W = 16;

endpackage

// *** src/ddr2_host.sv ***
// Command controller that drives a four-bank DDR2 memory over its pins.
// Assumes sys_clk at 200 MHz; the memory clock is made here by dividing it.
// Function
// - Bursts of four are never terminated or interrupted by the controller.
// - Power-down duration is bounded so refresh needs are still met.
// - Only deselect or NOP accompany power-down entry and exit.
// - Self refresh entered only with all banks idle, refresh with gate fall.
// - Only NOP is presented throughout the settle time after self-refresh exit.
// - No read for 200 link clocks after self-refresh exit.
// - Self-refresh exit carries NOP only.
// - No power-down during bursts, config writes or precharge.
// - Each new gate level is held for three link clock edges.
// - Unlisted state and gate sequences are illegal and never produced.
// - Gate stays high while driver calibration mode is active.
// - Termination control is always driven to a valid level.
// - Write mask travels with each write beat; high inhibits the beat.
// - Power-down entered only with the delay-locked loop locked.
// - Refresh is requested once per interval to cover all rows.
// - Exit latency elapses after power-down exit before any command.
`timescale 1ns/10ps

module ddr2_host #(
	parameter int ADDR_W = 12,
	parameter int DATA_W = 8,
	parameter int ROW_OPEN_CYC = 3,
	parameter int ROW_CLOSE_CYC = 3,
	parameter int REFRESH_CYC = 16,
	parameter int CONFIG_CYC = 2,
	parameter int WRITE_RECOVER_CYC = 3,
	parameter int READ_LATENCY_CYC = 3,
	parameter int WRITE_LATENCY_CYC = 2,
	parameter int PD_EXIT_CYC = 2,
	parameter int EXIT_SETTLE_CYC = 20,
	parameter int POWER_DOWN_MAX_CYC = ddr2_host_pkg::POWER_DOWN_MAX_DEF
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst_n,
	// User request port.
	input wire logic req_valid,
	input wire ddr2_host_pkg::op_t req_op,
	input wire logic [1:0] req_bank,
	input wire logic [ADDR_W-1:0] req_addr,
	output logic req_ready,
	output logic req_err,
	// Write beats supplied by the user.
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic wr_mask,
	output logic wr_take,
	// Read beats returned to the user.
	output logic [DATA_W-1:0] rd_data,
	output logic rd_valid,
	// Side controls and status.
	input wire logic odt_req,
	input wire logic calib_mode,
	input wire logic dll_locked,
	output logic refresh_due,
	// Memory pins.
	output logic mem_clk,
	output logic clock_gate_input,
	output logic chip_select_n,
	output logic row_strobe_n,
	output logic column_strobe_n,
	output logic write_strobe_n,
	output logic [1:0] memory_group_select,
	output logic [ADDR_W-1:0] mem_addr,
	output logic termination_control,
	output logic write_mask_pin,
	output logic [DATA_W-1:0] dq_out,
	input wire logic [DATA_W-1:0] dq_in,
	output logic dq_oe_n
);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_BUSY,
		ST_READ,
		ST_WRITE,
		ST_POWER_DOWN,
		ST_SELF_REFRESH,
		ST_EXIT
	} state_t;

	localparam int CW = ddr2_host_pkg::CNT_W;
	localparam logic [CW-1:0] ONE = CW'(1);
	localparam logic [CW-1:0] BURST_C = CW'(ddr2_host_pkg::BURST_LENGTH);
	localparam logic [1:0] HOLD_C = 2'(ddr2_host_pkg::GATE_MIN_HOLD);
	localparam logic [7:0] XSRD_C = 8'(ddr2_host_pkg::EXIT_READ_DELAY);
	localparam logic [CW-1:0] PD_MAX_C = CW'(POWER_DOWN_MAX_CYC);
	localparam logic [CW-1:0] REFI_C =
		CW'(ddr2_host_pkg::REFRESH_INTERVAL_CYC);

	state_t state_q;
	logic [CW-1:0] cnt_q;
	logic [3:0] bank_open_q;
	logic auto_q;
	logic [1:0] auto_bank_q;
	logic clk_q;
	logic cke_q;
	logic [3:0] cmd_q;
	logic [1:0] ba_q;
	logic [ADDR_W-1:0] addr_q;
	logic odt_q;
	logic [1:0] hold_q;
	logic [CW-1:0] pd_q;
	logic [CW-1:0] ref_q;
	logic [7:0] xsrd_q;
	logic [DATA_W-1:0] dq_out_q;
	logic dm_q;
	logic oe_n_q;
	logic [DATA_W-1:0] dq_s1_q;
	logic [DATA_W-1:0] dq_s2_q;
	logic [DATA_W-1:0] rd_data_q;
	logic rd_valid_q;
	logic tick;
	logic hold_ok;
	logic any_open;
	logic legal;
	logic take;
	logic issue;
	logic pd_force;
	logic wake;
	logic beat;

	// Everything but the read capture flops moves on the edge where the memory clock falls, so the
	// pins settle half a link period before the memory samples them.
	assign tick = clk_q;
	assign hold_ok = hold_q >= HOLD_C;
	assign any_open = |bank_open_q;
	assign beat = tick && (cnt_q <= BURST_C);

	// Legality of the request against the tracked state.
	always_comb begin
		legal = 1'b0;
		if (state_q == ST_IDLE) begin
			unique case (req_op)
			ddr2_host_pkg::OP_ROW_OPEN: legal = !bank_open_q[req_bank];
			ddr2_host_pkg::OP_READ,
			ddr2_host_pkg::OP_READ_AUTOCLOSE:
				legal = bank_open_q[req_bank] && (xsrd_q == 8'h00);
			ddr2_host_pkg::OP_WRITE,
			ddr2_host_pkg::OP_WRITE_AUTOCLOSE: legal = bank_open_q[req_bank];
			ddr2_host_pkg::OP_ROW_CLOSE,
			ddr2_host_pkg::OP_ROW_CLOSE_ALL: legal = 1'b1;
			ddr2_host_pkg::OP_REFRESH,
			ddr2_host_pkg::OP_CONFIG_WRITE: legal = !any_open;
			ddr2_host_pkg::OP_POWER_DOWN:
				legal = hold_ok && !calib_mode && dll_locked;
			ddr2_host_pkg::OP_SELF_REFRESH:
				legal = !any_open && hold_ok && !calib_mode && dll_locked;
			ddr2_host_pkg::OP_WAKE: legal = 1'b0;
			default: legal = 1'b0;
			endcase
		end else begin
			// Asleep, only a wake is meaningful, and only once held long enough.
			legal = (req_op == ddr2_host_pkg::OP_WAKE) && hold_ok;
		end
	end

	// Requests are taken only at a tick and only in settled states; bursts,
	// timed waits and exits stall the requester instead of refusing it.
	assign pd_force = tick && (state_q == ST_POWER_DOWN) && hold_ok &&
		(pd_q >= PD_MAX_C);
	assign req_ready = tick && !pd_force && ((state_q == ST_IDLE) ||
		(state_q == ST_POWER_DOWN) || (state_q == ST_SELF_REFRESH));
	assign take = req_valid && req_ready;
	assign issue = take && legal;
	assign req_err = take && !legal;
	assign wake = pd_force || (issue && (state_q != ST_IDLE));

	// Memory clock divider; the memory sees one cycle per two system cycles.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			clk_q <= 1'b0;
		end else begin
			clk_q <= !clk_q;
		end
	end

	// Bank tracking and sequencing through the timed states.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			cnt_q <= '0;
			bank_open_q <= 4'h0;
			auto_q <= 1'b0;
			auto_bank_q <= 2'h0;
		end else if (tick) begin
			unique case (state_q)
			ST_IDLE: begin
				if (issue) begin
					unique case (req_op)
					ddr2_host_pkg::OP_ROW_OPEN: begin
						bank_open_q[req_bank] <= 1'b1;
						state_q <= ST_BUSY;
						cnt_q <= CW'(ROW_OPEN_CYC);
					end
					ddr2_host_pkg::OP_READ,
					ddr2_host_pkg::OP_READ_AUTOCLOSE: begin
						auto_q <= req_op == ddr2_host_pkg::OP_READ_AUTOCLOSE;
						auto_bank_q <= req_bank;
						state_q <= ST_READ;
						cnt_q <= CW'(READ_LATENCY_CYC) + BURST_C;
					end
					ddr2_host_pkg::OP_WRITE,
					ddr2_host_pkg::OP_WRITE_AUTOCLOSE: begin
						auto_q <= req_op == ddr2_host_pkg::OP_WRITE_AUTOCLOSE;
						auto_bank_q <= req_bank;
						state_q <= ST_WRITE;
						cnt_q <= CW'(WRITE_LATENCY_CYC) + BURST_C;
					end
					ddr2_host_pkg::OP_ROW_CLOSE: begin
						bank_open_q[req_bank] <= 1'b0;
						state_q <= ST_BUSY;
						cnt_q <= CW'(ROW_CLOSE_CYC);
					end
					ddr2_host_pkg::OP_ROW_CLOSE_ALL: begin
						bank_open_q <= 4'h0;
						state_q <= ST_BUSY;
						cnt_q <= CW'(ROW_CLOSE_CYC);
					end
					ddr2_host_pkg::OP_REFRESH: begin
						state_q <= ST_BUSY;
						cnt_q <= CW'(REFRESH_CYC);
					end
					ddr2_host_pkg::OP_CONFIG_WRITE: begin
						state_q <= ST_BUSY;
						cnt_q <= CW'(CONFIG_CYC);
					end
					ddr2_host_pkg::OP_POWER_DOWN: state_q <= ST_POWER_DOWN;
					ddr2_host_pkg::OP_SELF_REFRESH: state_q <= ST_SELF_REFRESH;
					ddr2_host_pkg::OP_WAKE: state_q <= ST_IDLE;
					default: state_q <= ST_IDLE;
					endcase
				end
			end
			ST_BUSY, ST_EXIT: begin
				// Config writes, closes and exit latency all finish here.
				if (cnt_q <= ONE) begin
					state_q <= ST_IDLE;
				end else begin
					cnt_q <= cnt_q - ONE;
				end
			end
			ST_READ: begin
				if (cnt_q <= ONE) begin
					if (auto_q) begin
						bank_open_q[auto_bank_q] <= 1'b0;
						state_q <= ST_BUSY;
						cnt_q <= CW'(ROW_CLOSE_CYC);
					end else begin
						state_q <= ST_IDLE;
					end
				end else begin
					cnt_q <= cnt_q - ONE;
				end
			end
			ST_WRITE: begin
				// Write recovery always follows; an auto-close adds the close.
				if (cnt_q <= ONE) begin
					state_q <= ST_BUSY;
					if (auto_q) begin
						bank_open_q[auto_bank_q] <= 1'b0;
						cnt_q <= CW'(WRITE_RECOVER_CYC + ROW_CLOSE_CYC);
					end else begin
						cnt_q <= CW'(WRITE_RECOVER_CYC);
					end
				end else begin
					cnt_q <= cnt_q - ONE;
				end
			end
			ST_POWER_DOWN: begin
				if (wake) begin
					state_q <= ST_EXIT;
					cnt_q <= CW'(PD_EXIT_CYC);
				end
			end
			ST_SELF_REFRESH: begin
				if (wake) begin
					state_q <= ST_EXIT;
					cnt_q <= CW'(EXIT_SETTLE_CYC);
				end
			end
			endcase
		end
	end

	// Command pins and the clock gate. A NOP stands on every tick that does
	// not issue, so bursts and exit windows carry nothing else.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cmd_q <= ddr2_host_pkg::CMD_NOP;
			cke_q <= 1'b1;
			ba_q <= 2'h0;
			addr_q <= '0;
			hold_q <= HOLD_C;
		end else if (tick) begin
			cmd_q <= ddr2_host_pkg::CMD_NOP;
			if (hold_q < HOLD_C) begin
				hold_q <= hold_q + 2'h1;
			end
			if (wake) begin
				cke_q <= 1'b1;
				hold_q <= 2'h1;
			end else if (issue) begin
				ba_q <= req_bank;
				addr_q <= req_addr;
				unique case (req_op)
				ddr2_host_pkg::OP_ROW_OPEN: cmd_q <= ddr2_host_pkg::CMD_ROW_OPEN;
				ddr2_host_pkg::OP_READ,
				ddr2_host_pkg::OP_READ_AUTOCLOSE: begin
					cmd_q <= ddr2_host_pkg::CMD_READ;
					addr_q[ddr2_host_pkg::AUTOCLOSE_BIT] <=
						req_op == ddr2_host_pkg::OP_READ_AUTOCLOSE;
				end
				ddr2_host_pkg::OP_WRITE,
				ddr2_host_pkg::OP_WRITE_AUTOCLOSE: begin
					cmd_q <= ddr2_host_pkg::CMD_WRITE;
					addr_q[ddr2_host_pkg::AUTOCLOSE_BIT] <=
						req_op == ddr2_host_pkg::OP_WRITE_AUTOCLOSE;
				end
				ddr2_host_pkg::OP_ROW_CLOSE,
				ddr2_host_pkg::OP_ROW_CLOSE_ALL: begin
					cmd_q <= ddr2_host_pkg::CMD_ROW_CLOSE;
					addr_q[ddr2_host_pkg::AUTOCLOSE_BIT] <=
						req_op == ddr2_host_pkg::OP_ROW_CLOSE_ALL;
				end
				ddr2_host_pkg::OP_REFRESH: cmd_q <= ddr2_host_pkg::CMD_REFRESH;
				ddr2_host_pkg::OP_CONFIG_WRITE: cmd_q <= ddr2_host_pkg::CMD_CONFIG;
				ddr2_host_pkg::OP_POWER_DOWN: begin
					cke_q <= 1'b0;
					hold_q <= 2'h1;
				end
				ddr2_host_pkg::OP_SELF_REFRESH: begin
					cmd_q <= ddr2_host_pkg::CMD_REFRESH;
					cke_q <= 1'b0;
					hold_q <= 2'h1;
				end
				ddr2_host_pkg::OP_WAKE: cke_q <= 1'b1;
				default: cmd_q <= ddr2_host_pkg::CMD_NOP;
				endcase
			end
		end
	end

	// Termination follows the user level and is always driven; it is
	// parked low in self refresh, where the memory flags a high level as a fault.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			odt_q <= 1'b0;
		end else if (tick) begin
			odt_q <= odt_req && (state_q != ST_SELF_REFRESH);
		end
	end

	// Power-down length, refresh interval and post-exit read delay.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pd_q <= '0;
			ref_q <= '0;
			xsrd_q <= 8'h00;
		end else if (tick) begin
			if (state_q == ST_POWER_DOWN && pd_q < PD_MAX_C) begin
				pd_q <= pd_q + ONE;
			end else if (state_q != ST_POWER_DOWN) begin
				pd_q <= '0;
			end
			// The memory refreshes itself while asleep in self refresh.
			if ((issue && req_op == ddr2_host_pkg::OP_REFRESH) ||
				state_q == ST_SELF_REFRESH) begin
				ref_q <= '0;
			end else if (ref_q < REFI_C) begin
				ref_q <= ref_q + ONE;
			end
			if (wake && state_q == ST_SELF_REFRESH) begin
				xsrd_q <= XSRD_C;
			end else if (xsrd_q != 8'h00) begin
				xsrd_q <= xsrd_q - 8'h01;
			end
		end
	end

	assign refresh_due = ref_q >= REFI_C;

	// Write beats: each data word leaves with its own mask bit.
	assign wr_take = beat && (state_q == ST_WRITE);
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			dq_out_q <= '0;
			dm_q <= 1'b1;
			oe_n_q <= 1'b1;
		end else if (tick) begin
			oe_n_q <= !wr_take;
			dm_q <= wr_take ? wr_mask : 1'b1;
			if (wr_take) begin
				dq_out_q <= wr_data;
			end
		end
	end

	// Read beats: the data pins pass two flops before they are captured.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			dq_s1_q <= '0;
			dq_s2_q <= '0;
			rd_data_q <= '0;
			rd_valid_q <= 1'b0;
		end else begin
			dq_s1_q <= dq_in;
			dq_s2_q <= dq_s1_q;
			rd_valid_q <= beat && (state_q == ST_READ);
			if (beat && (state_q == ST_READ)) begin
				rd_data_q <= dq_s2_q;
			end
		end
	end

	assign mem_clk = clk_q;
	assign clock_gate_input = cke_q;
	assign {chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n} = cmd_q;
	assign memory_group_select = ba_q;
	assign mem_addr = addr_q;
	assign termination_control = odt_q;
	assign write_mask_pin = dm_q;
	assign dq_out = dq_out_q;
	assign dq_oe_n = oe_n_q;
	assign rd_data = rd_data_q;
	assign rd_valid = rd_valid_q;

	// Checks on what this controller drives onto the memory pins.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence seq_gate_turn;
		$changed(cke_q);
	endsequence

	sequence seq_gate_steady;
		$stable(cke_q) [*5];
	endsequence

	AST_GATE_HOLD: assert property (seq_gate_turn |=> seq_gate_steady)
		else $error("clock gate changed before three link edges");
	AST_PD_ENTRY_NOP: assert property (($fell(cke_q) &&
		cmd_q != ddr2_host_pkg::CMD_REFRESH) |-> cmd_q == ddr2_host_pkg::CMD_NOP)
		else $error("power-down entry carried a command");
	AST_SREF_IDLE: assert property (($fell(cke_q) &&
		cmd_q == ddr2_host_pkg::CMD_REFRESH) |-> bank_open_q == 4'h0)
		else $error("self refresh entered with a bank open");
	AST_WAKE_NOP: assert property ($rose(cke_q) |->
		cmd_q == ddr2_host_pkg::CMD_NOP)
		else $error("wake carried a command");
	AST_EXIT_QUIET: assert property (state_q == ST_EXIT |->
		cmd_q == ddr2_host_pkg::CMD_NOP && cke_q)
		else $error("command during exit settle time");
	AST_READ_DELAY: assert property ($changed(cmd_q) &&
		cmd_q == ddr2_host_pkg::CMD_READ |-> xsrd_q == 8'h00)
		else $error("read too soon after self refresh exit");
	AST_BURST_WHOLE: assert property ((state_q inside {ST_READ, ST_WRITE} &&
		$past(state_q, 2) inside {ST_READ, ST_WRITE}) |->
		cmd_q == ddr2_host_pkg::CMD_NOP)
		else $error("burst interrupted");
	AST_PD_BOUND: assert property (state_q == ST_POWER_DOWN |->
		pd_q <= PD_MAX_C)
		else $error("power-down held too long");
	AST_CALIB_HIGH: assert property ($fell(cke_q) |-> !$past(calib_mode))
		else $error("gate dropped during driver calibration");
	AST_MASK_ALIGN: assert property (wr_take |=>
		write_mask_pin == $past(wr_mask) && !dq_oe_n)
		else $error("mask not aligned with write beat");
	AST_REFUSE: assert property (req_err |=>
		cmd_q == ddr2_host_pkg::CMD_NOP)
		else $error("refused request reached the pins");

endmodule

// *** tb/ddr2_dev_model.sv ***
// Behavioural four-bank memory that answers the command controller.
// Assumes pins are launched away from the rising edge of mem_clk.
`timescale 1ns/10ps
module ddr2_dev_model (
	// Memory pins.
	input wire logic mem_clk,
	input wire logic clock_gate_input,
	input wire logic chip_select_n,
	input wire logic row_strobe_n,
	input wire logic column_strobe_n,
	input wire logic write_strobe_n,
	input wire logic [1:0] memory_group_select,
	input wire logic [11:0] mem_addr,
	input wire logic termination_control,
	input wire logic write_mask_pin,
	input wire logic [7:0] dq_out,
	input wire logic dq_oe_n,
	output logic [7:0] dq_in,
	// State for the bench.
	output logic in_pd,
	output logic in_sr,
	output logic [3:0] banks,
	output logic [7:0] bad
);
	logic [3:0] cmd;
	logic quiet;
	logic gate_q = 1'b1;
	logic [1:0] hold_q = 2'h3;
	logic [7:0] mem_q [4] = '{default: 8'h00};
	logic [1:0] bk;
	logic [1:0] rb_q = 2'h0;
	logic [1:0] wb_q = 2'h0;
	logic [3:0] rd_q = 4'h0;
	logic pd_r = 1'b0;
	logic sr_r = 1'b0;
	logic [3:0] open_r = 4'h0;
	logic [7:0] bad_r = 8'h00;

	// Strobes and gate form one command per edge.
	assign cmd = {chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n};
	assign quiet = cmd[3] || cmd == ddr2_host_pkg::CMD_NOP;
	assign bk = memory_group_select;
	assign in_pd = pd_r;
	assign in_sr = sr_r;
	assign banks = open_r;
	assign bad = bad_r;

	// Everything is judged from current and previous gate level.
	always @(posedge mem_clk) begin
		gate_q <= clock_gate_input;
		rd_q <= (rd_q != 4'h0) ? rd_q - 4'h1 : rd_q;
		if (gate_q != clock_gate_input) begin
			hold_q <= 2'h1;
			if (hold_q != 2'h3)
				bad_r = bad_r + 8'h01;
		end else if (hold_q != 2'h3) begin
			hold_q <= hold_q + 2'h1;
		end
		if (sr_r && termination_control)
			bad_r = bad_r + 8'h01;
		if (!dq_oe_n && !write_mask_pin)
			mem_q[wb_q] <= dq_out;
		if (gate_q && !clock_gate_input) begin
			if (cmd == ddr2_host_pkg::CMD_REFRESH && open_r == 4'h0)
				sr_r <= 1'b1;
			else if (quiet)
				pd_r <= 1'b1;
			else
				bad_r = bad_r + 8'h01;
		end else if (!gate_q && clock_gate_input) begin
			pd_r <= 1'b0;
			if (!quiet)
				bad_r = bad_r + 8'h01;
		end else if (clock_gate_input && !cmd[3]) begin
			case (cmd)
			ddr2_host_pkg::CMD_ROW_OPEN: begin
				if (open_r[bk])
					bad_r = bad_r + 8'h01;
				open_r[bk] <= 1'b1;
			end
			ddr2_host_pkg::CMD_ROW_CLOSE: begin
				if (mem_addr[10])
					open_r <= 4'h0;
				else
					open_r[bk] <= 1'b0;
			end
			ddr2_host_pkg::CMD_READ, ddr2_host_pkg::CMD_WRITE: begin
				if (!open_r[bk])
					bad_r = bad_r + 8'h01;
				if (mem_addr[10])
					open_r[bk] <= 1'b0;
				if (cmd == ddr2_host_pkg::CMD_READ) begin
					rb_q <= bk;
					rd_q <= 4'ha;
				end else begin
					wb_q <= bk;
				end
			end
			ddr2_host_pkg::CMD_REFRESH, ddr2_host_pkg::CMD_CONFIG: begin
				if (open_r != 4'h0)
					bad_r = bad_r + 8'h01;
			end
			default: ;
			endcase
		end
	end

	// Exit from self refresh is seen on the gate rise itself.
	always @(posedge clock_gate_input) begin
		sr_r <= 1'b0;
	end

	// A released data line shows the inverse, never the old value.
	assign dq_in = (rd_q != 4'h0) ? mem_q[rb_q] : ~mem_q[rb_q];
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the DDR2 command controller.
// Assumes the controller divides sys_clk to make the memory clock.
`timescale 1ns/10ps
module testbench;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic req_valid = 1'b0;
	ddr2_host_pkg::op_t req_op = ddr2_host_pkg::OP_ROW_OPEN;
	logic [1:0] req_bank = 2'h0;
	logic [11:0] req_addr = 12'h0a5;
	logic [7:0] wr_data = 8'ha0;
	logic wr_mask = 1'b0;
	logic odt_req = 1'b0;
	logic calib_mode = 1'b0;
	logic dll_locked = 1'b1;
	logic req_ready, req_err, wr_take, rd_valid, refresh_due, mem_clk;
	logic clock_gate_input, chip_select_n, row_strobe_n, column_strobe_n;
	logic write_strobe_n, termination_control, write_mask_pin, dq_oe_n;
	logic [1:0] memory_group_select;
	logic [11:0] mem_addr;
	logic [7:0] rd_data, dq_out, dq_in, bad;
	logic in_pd, in_sr;
	logic [3:0] banks;
	logic [7:0] rd_exp = 8'h00;
	int fails = 0;
	int check_count = 0;
	int cyc = 0;
	int takes = 0;
	int rds = 0;

	ddr2_host #(.POWER_DOWN_MAX_CYC(40)) u_dut (.sys_clk, .rst_n,
		.req_valid, .req_op, .req_bank, .req_addr, .req_ready, .req_err,
		.wr_data, .wr_mask, .wr_take, .rd_data, .rd_valid, .odt_req,
		.calib_mode, .dll_locked, .refresh_due, .mem_clk, .clock_gate_input,
		.chip_select_n, .row_strobe_n, .column_strobe_n, .write_strobe_n,
		.memory_group_select, .mem_addr, .termination_control,
		.write_mask_pin, .dq_out, .dq_in, .dq_oe_n);

	ddr2_dev_model u_mem (.mem_clk, .clock_gate_input, .chip_select_n,
		.row_strobe_n, .column_strobe_n, .write_strobe_n,
		.memory_group_select, .mem_addr, .termination_control,
		.write_mask_pin, .dq_out, .dq_oe_n, .dq_in, .in_pd, .in_sr,
		.banks, .bad);

	// Free-running system clock.
	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic check(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Holds the request until a ready tick, then judges the refusal flag.
	task automatic do_req(input ddr2_host_pkg::op_t op, input logic [1:0] b,
		input logic e);
		int n;
		n = 0;
		@(posedge sys_clk);
		req_valid <= 1'b1;
		req_op <= op;
		req_bank <= b;
		do begin
			@(negedge sys_clk);
			n++;
		end while (req_ready !== 1'b1 && n < 1000);
		check("req_ready", 8'h01, 8'(req_ready));
		check("req_err", 8'(e), 8'(req_err));
		@(posedge sys_clk);
		req_valid <= 1'b0;
	endtask

	// Write beats follow wr_take; read beats are compared as they come.
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (wr_take === 1'b1) begin
			takes <= takes + 1;
			wr_data <= wr_data + 8'h01;
			wr_mask <= ~wr_mask;
		end
		if (rd_valid === 1'b1) begin
			rds <= rds + 1;
			check("rd_data", rd_exp, rd_data);
		end
		if (cyc == 20000) begin
			fails++;
			end_sim();
		end
	end

	task automatic t_reset();
		check("cke", 8'h01, 8'(clock_gate_input));
		check("cmd", 8'(ddr2_host_pkg::CMD_NOP), 8'({chip_select_n,
			row_strobe_n, column_strobe_n, write_strobe_n}));
		check("mask", 8'h01, 8'(write_mask_pin));
		check("oe", 8'h01, 8'(dq_oe_n));
		check("refresh_due", 8'h00, 8'(refresh_due));
		$display("reset test done");
	endtask

	task automatic t_banks();
		do_req(ddr2_host_pkg::OP_READ, 2'h1, 1'b1);
		do_req(ddr2_host_pkg::OP_WRITE, 2'h1, 1'b1);
		do_req(ddr2_host_pkg::OP_ROW_OPEN, 2'h1, 1'b0);
		do_req(ddr2_host_pkg::OP_ROW_OPEN, 2'h1, 1'b1);
		do_req(ddr2_host_pkg::OP_REFRESH, 2'h0, 1'b1);
		do_req(ddr2_host_pkg::OP_CONFIG_WRITE, 2'h0, 1'b1);
		check("banks", 8'h02, 8'(banks));
		do_req(ddr2_host_pkg::OP_ROW_CLOSE_ALL, 2'h0, 1'b0);
		do_req(ddr2_host_pkg::OP_CONFIG_WRITE, 2'h2, 1'b0);
		do_req(ddr2_host_pkg::OP_REFRESH, 2'h0, 1'b0);
		$display("bank test done");
	endtask

	// Two writes back to back: the second waits, no beat is lost.
	task automatic t_burst();
		do_req(ddr2_host_pkg::OP_ROW_OPEN, 2'h2, 1'b0);
		takes = 0;
		do_req(ddr2_host_pkg::OP_WRITE, 2'h2, 1'b0);
		do_req(ddr2_host_pkg::OP_WRITE, 2'h2, 1'b0);
		repeat (40) @(posedge sys_clk);
		check("beats", 8'h08, 8'(takes));
		rds = 0;
		rd_exp = 8'ha6;
		do_req(ddr2_host_pkg::OP_READ_AUTOCLOSE, 2'h2, 1'b0);
		repeat (40) @(posedge sys_clk);
		check("reads", 8'h04, 8'(rds));
		check("banks", 8'h00, 8'(banks));
		$display("burst test done");
	endtask

	task automatic t_power();
		do_req(ddr2_host_pkg::OP_ROW_OPEN, 2'h0, 1'b0);
		calib_mode <= 1'b1;
		do_req(ddr2_host_pkg::OP_POWER_DOWN, 2'h0, 1'b1);
		calib_mode <= 1'b0;
		dll_locked <= 1'b0;
		do_req(ddr2_host_pkg::OP_POWER_DOWN, 2'h0, 1'b1);
		dll_locked <= 1'b1;
		do_req(ddr2_host_pkg::OP_POWER_DOWN, 2'h0, 1'b0);
		do_req(ddr2_host_pkg::OP_WAKE, 2'h0, 1'b1);
		check("pd", 8'h01, 8'(in_pd));
		do_req(ddr2_host_pkg::OP_ROW_OPEN, 2'h1, 1'b1);
		repeat (8) @(posedge sys_clk);
		do_req(ddr2_host_pkg::OP_WAKE, 2'h0, 1'b0);
		repeat (4) @(posedge sys_clk);
		check("pd", 8'h00, 8'(in_pd));
		do_req(ddr2_host_pkg::OP_ROW_CLOSE_ALL, 2'h0, 1'b0);
		repeat (8) @(posedge sys_clk);
		do_req(ddr2_host_pkg::OP_POWER_DOWN, 2'h0, 1'b0);
		repeat (10) @(posedge sys_clk);
		check("pd", 8'h01, 8'(in_pd));
		repeat (90) @(posedge sys_clk);
		check("pd", 8'h00, 8'(in_pd));
		$display("power-down test done");
	endtask

	task automatic t_self();
		repeat (8) @(posedge sys_clk);
		do_req(ddr2_host_pkg::OP_ROW_OPEN, 2'h0, 1'b0);
		do_req(ddr2_host_pkg::OP_SELF_REFRESH, 2'h0, 1'b1);
		do_req(ddr2_host_pkg::OP_ROW_CLOSE_ALL, 2'h0, 1'b0);
		odt_req <= 1'b1;
		do_req(ddr2_host_pkg::OP_SELF_REFRESH, 2'h0, 1'b0);
		repeat (8) @(posedge sys_clk);
		check("sr", 8'h01, 8'(in_sr));
		check("odt", 8'h00, 8'(termination_control));
		do_req(ddr2_host_pkg::OP_REFRESH, 2'h0, 1'b1);
		do_req(ddr2_host_pkg::OP_WAKE, 2'h0, 1'b0);
		odt_req <= 1'b0;
		// Half a cycle on the gate has risen but no memory clock edge has.
		@(negedge sys_clk);
		check("sr", 8'h00, 8'(in_sr));
		do_req(ddr2_host_pkg::OP_ROW_OPEN, 2'h0, 1'b0);
		do_req(ddr2_host_pkg::OP_READ, 2'h0, 1'b1);
		repeat (400) @(posedge sys_clk);
		rds = 0;
		rd_exp = 8'h00;
		do_req(ddr2_host_pkg::OP_READ, 2'h0, 1'b0);
		repeat (40) @(posedge sys_clk);
		check("reads", 8'h04, 8'(rds));
		// No refresh is asked for here, so the flag must come up in time.
		check("refresh_due", 8'h00, 8'(refresh_due));
		repeat (2 * ddr2_host_pkg::REFRESH_INTERVAL_CYC) @(posedge sys_clk);
		check("refresh_due", 8'h01, 8'(refresh_due));
		check("bad", 8'h00, bad);
		$display("self-refresh test done");
	endtask

	// Main sequence.
	initial begin
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		t_reset();
		t_banks();
		t_burst();
		t_power();
		t_self();
		end_sim();
	end
endmodule
